// ==== core/bmv_core.sv ====
// file: block-move engine with state counting and condition-flag helper
`timescale 1ns/1ps
module bmv_core #(
  parameter int FIFO_DEPTH = bmv_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        ARST_N,
  // block-move command
  input  wire logic        START,
  input  wire logic        WORD_MODE,
  input  wire logic [31:0] SRC_PTR_IN,
  input  wire logic [31:0] DST_PTR_IN,
  input  wire logic [15:0] COUNT_IN,
  input  wire logic        EXR_VALID,
  input  wire logic        OFF_CHIP_WAIT,
  // block-move status
  output logic             BUSY,
  output logic             DONE,
  output logic [15:0]      STATE_COUNT,
  output logic [31:0]      SRC_PTR_OUT,
  output logic [31:0]      DST_PTR_OUT,
  output logic [15:0]      COUNT_OUT,
  // memory read port
  output logic             RD_REQ,
  output logic [31:0]      RD_ADDR,
  input  wire logic        RD_VALID,
  input  wire logic [7:0]  RD_DATA,
  // memory write port
  output logic             WR_REQ,
  output logic [31:0]      WR_ADDR,
  output logic [7:0]       WR_DATA,
  input  wire logic        WR_READY,
  // save/restore state count query
  input  wire logic [2:0]  LDM_REGS,
  output logic [3:0]       LDM_STATES,
  // flag unit
  input  wire logic        FLAG_REQ,
  input  wire logic [1:0]  FLAG_OP,
  input  wire logic [1:0]  FLAG_SIZE,
  input  wire logic [31:0] OPND_A,
  input  wire logic [31:0] OPND_B,
  input  wire logic        OPND_SUB,
  input  wire logic        ZERO_IN,
  output logic             HALF_CARRY,
  output logic             ZERO_FLAG,
  output logic             DIV_FLAG,
  output logic [1:0]       FLAG_STATES
);
  bmv_pkg::bmv_state_t state_reg;
  bmv_pkg::bmv_state_t state_next;
  logic [31:0] src_reg;
  logic [31:0] dst_reg;
  logic [15:0] cnt_reg;
  logic [15:0] rd_left_reg;
  logic [15:0] states_reg;
  logic        busy_reg;
  logic        done_reg;
  logic        rd_req_reg;
  logic [31:0] rd_addr_reg;
  logic        wait_s1_reg;
  logic        wait_s2_reg;
  wire         f_in_ready;
  wire         f_out_valid;
  wire  [7:0]  f_out_data;
  wire  [15:0] count_sel;
  wire         wr_fire;
  wire         rd_issue;

  // byte form uses only the low count byte
  assign count_sel = WORD_MODE ? COUNT_IN : {8'h00, COUNT_IN[7:0]};
  assign wr_fire   = (state_reg == bmv_pkg::BMV_COPY) && f_out_valid && WR_READY;
  // a read is issued only while the fifo can take the answer
  assign rd_issue  = (state_reg == bmv_pkg::BMV_COPY) && (rd_left_reg != 16'h0000) && f_in_ready && !rd_req_reg;

  // off-chip wait is a pin level, so it is synchronised first
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wait_s1_reg <= 1'b0;
      wait_s2_reg <= 1'b0;
    end else begin
      wait_s1_reg <= OFF_CHIP_WAIT;
      wait_s2_reg <= wait_s1_reg;
    end
  end

  // engine sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      bmv_pkg::BMV_IDLE:  if (START) state_next = bmv_pkg::BMV_SETUP;
      bmv_pkg::BMV_SETUP: state_next = (cnt_reg == 16'h0000) ? bmv_pkg::BMV_DONE : bmv_pkg::BMV_COPY;
      bmv_pkg::BMV_COPY:  if (wr_fire && cnt_reg == 16'h0001) state_next = bmv_pkg::BMV_DONE;
      bmv_pkg::BMV_DONE:  state_next = bmv_pkg::BMV_IDLE;
      default:            state_next = bmv_pkg::BMV_IDLE;
    endcase
  end

  // state register and command capture
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= bmv_pkg::BMV_IDLE;
      src_reg   <= '0;
      dst_reg   <= '0;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      if (state_reg == bmv_pkg::BMV_IDLE && START) begin
        src_reg <= SRC_PTR_IN;
        dst_reg <= DST_PTR_IN;
        cnt_reg <= count_sel;
      end else if (wr_fire) begin
        src_reg <= src_reg + 32'h1;
        dst_reg <= dst_reg + 32'h1;
        cnt_reg <= cnt_reg - 16'h1;
      end
    end
  end

  // read side runs ahead of writes, bounded by fifo space
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_left_reg <= '0;
      rd_req_reg  <= 1'b0;
      rd_addr_reg <= '0;
    end else begin
      if (state_reg == bmv_pkg::BMV_IDLE && START) begin
        rd_left_reg <= count_sel;
        rd_addr_reg <= SRC_PTR_IN;
      end else if (rd_issue) begin
        rd_req_reg  <= 1'b1;
        rd_left_reg <= rd_left_reg - 16'h1;
      end else if (rd_req_reg && RD_VALID) begin
        rd_req_reg  <= 1'b0;
        rd_addr_reg <= rd_addr_reg + 32'h1;
      end
    end
  end

  // state accounting: base plus two per byte plus off-chip wait cycles on which no byte is written
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      states_reg <= '0;
      busy_reg   <= 1'b0;
      done_reg   <= 1'b0;
    end else begin
      done_reg <= (state_reg == bmv_pkg::BMV_DONE);
      if (state_reg == bmv_pkg::BMV_IDLE && START) begin
        busy_reg   <= 1'b1;
        // the extended control register surcharge belongs to flagged ops only, not to moves
        states_reg <= 16'(bmv_pkg::MOVE_BASE_STATES);
      end else if (state_reg == bmv_pkg::BMV_DONE) begin
        busy_reg <= 1'b0;
      end else if (busy_reg) begin
        if (wr_fire) states_reg <= states_reg + 16'(bmv_pkg::MOVE_PER_BYTE);
        else if (wait_s2_reg) states_reg <= states_reg + 16'h1;
      end
    end
  end

  bmv_fifo #(
    .WIDTH (bmv_pkg::DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (MCLK),
    .arst_n    (ARST_N),
    .in_valid  (rd_req_reg && RD_VALID),
    .in_ready  (f_in_ready),
    .in_data   (RD_DATA),
    .out_valid (f_out_valid),
    .out_ready (wr_fire),
    .out_data  (f_out_data)
  );

  // flag unit: half-carry taps the carry out of bit 11 / 27
  wire [12:0] hc_w_sum  = OPND_SUB ? {1'b0, OPND_A[11:0]} - {1'b0, OPND_B[11:0]}
                                   : {1'b0, OPND_A[11:0]} + {1'b0, OPND_B[11:0]};
  wire [28:0] hc_l_sum  = OPND_SUB ? {1'b0, OPND_A[27:0]} - {1'b0, OPND_B[27:0]}
                                   : {1'b0, OPND_A[27:0]} + {1'b0, OPND_B[27:0]};
  wire        hc_word   = hc_w_sum[bmv_pkg::HC_BIT_WORD+1];
  wire        hc_long   = hc_l_sum[bmv_pkg::HC_BIT_LONG+1];
  wire        res_zero  = (OPND_A == 32'h0);
  wire        div_neg   = (FLAG_SIZE == bmv_pkg::BMV_SZ_WORD) ? OPND_B[15] :
                          (FLAG_SIZE == bmv_pkg::BMV_SZ_LONG) ? OPND_B[31] : OPND_B[7];
  wire [3:0]  ldm_sel   = (LDM_REGS == 3'h2) ? 4'(bmv_pkg::LDM_STATES_2) :
                          (LDM_REGS == 3'h3) ? 4'(bmv_pkg::LDM_STATES_3) :
                          (LDM_REGS == 3'h4) ? 4'(bmv_pkg::LDM_STATES_4) : 4'h0;

  // flags latch on request; extended ops take OPND_A as result
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      HALF_CARRY  <= 1'b0;
      ZERO_FLAG   <= 1'b0;
      DIV_FLAG    <= 1'b0;
      FLAG_STATES <= '0;
      LDM_STATES  <= '0;
    end else begin
      LDM_STATES <= ldm_sel;
      if (FLAG_REQ) begin
        FLAG_STATES <= 2'h1 + (EXR_VALID ? 2'(bmv_pkg::EXR_EXTRA_STATES) : 2'h0);
        case (FLAG_OP)
          bmv_pkg::BMV_FOP_ADDSUB: HALF_CARRY <= (FLAG_SIZE == bmv_pkg::BMV_SZ_LONG) ? hc_long : hc_word;
          bmv_pkg::BMV_FOP_EXTEND: ZERO_FLAG  <= res_zero ? ZERO_IN : 1'b0;
          bmv_pkg::BMV_FOP_DIVIDE: DIV_FLAG   <= div_neg;
          default:                 DIV_FLAG   <= DIV_FLAG;
        endcase
      end
    end
  end

  // registered outputs
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BUSY <= 1'b0; DONE <= 1'b0; STATE_COUNT <= '0;
      SRC_PTR_OUT <= '0; DST_PTR_OUT <= '0; COUNT_OUT <= '0;
      RD_REQ <= 1'b0; RD_ADDR <= '0; WR_REQ <= 1'b0; WR_ADDR <= '0; WR_DATA <= '0;
    end else begin
      BUSY <= busy_reg; DONE <= done_reg; STATE_COUNT <= states_reg;
      SRC_PTR_OUT <= src_reg; DST_PTR_OUT <= dst_reg; COUNT_OUT <= cnt_reg;
      RD_REQ <= rd_req_reg; RD_ADDR <= rd_addr_reg;
      WR_REQ <= (state_reg == bmv_pkg::BMV_COPY) && f_out_valid;
      WR_ADDR <= dst_reg; WR_DATA <= f_out_data;
    end
  end
endmodule

// ==== common/bmv_pkg.sv ====
// package: shared constants for the block-move and flag timing unit
package bmv_pkg;
  localparam int ADDR_W            = 32;
  localparam int DATA_W            = 8;
  localparam int CNT_W             = 16;
  localparam int FIFO_DEPTH        = 8;
  // state counts, in cpu states of the core clock
  localparam int MOVE_BASE_STATES  = 4;
  localparam int MOVE_PER_BYTE     = 2;
  localparam int LDM_STATES_2      = 7;
  localparam int LDM_STATES_3      = 9;
  localparam int LDM_STATES_4      = 11;
  localparam int EXR_EXTRA_STATES  = 1;
  // half-carry bit positions
  localparam int HC_BIT_WORD       = 11;
  localparam int HC_BIT_LONG       = 27;
  // operand sizes for the flag unit
  typedef enum logic [1:0] {
    BMV_SZ_BYTE = 2'h0,
    BMV_SZ_WORD = 2'h1,
    BMV_SZ_LONG = 2'h2
  } bmv_size_t;
  // flag operation kinds
  typedef enum logic [1:0] {
    BMV_FOP_ADDSUB = 2'h0,
    BMV_FOP_EXTEND = 2'h1,
    BMV_FOP_DIVIDE = 2'h2
  } bmv_fop_t;
  // block-move engine states, gray along the usual path
  typedef enum logic [1:0] {
    BMV_IDLE  = 2'b00,
    BMV_SETUP = 2'b01,
    BMV_COPY  = 2'b11,
    BMV_DONE  = 2'b10
  } bmv_state_t;
endpackage

// ==== core/bmv_fifo.sv ====
// file: parameterised valid/ready fifo for the block-move data path
`timescale 1ns/1ps
module bmv_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  wire              do_wr;
  wire              do_rd;

  // honest full and empty from the occupancy count
  assign in_ready  = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  // storage has no reset, only pointers and count do
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointer and count update; wrap relies on power-of-two depth
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (do_wr) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (do_rd) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (PW+1)'(do_wr) - (PW+1)'(do_rd);
    end
  end
endmodule

// ==== tb/bmv_mem_model.sv ====
// on-chip memory model for the block-move read and write ports
`timescale 1ns/1ps
module bmv_mem_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // read port
  input  wire logic        rd_req,
  input  wire logic [31:0] rd_addr,
  output logic             rd_valid,
  output logic [7:0]       rd_data,
  // write pacing
  output logic             wr_ready,
  input  wire logic        stall,
  input  wire logic [3:0]  lat
);
  logic [3:0] wait_reg;
  // answer after lat cycles; count restarts after a hit, so for lat of one or more the stale request is never answered
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_reg <= 4'h0;
      rd_valid <= 1'b0;
      rd_data  <= 8'h00;
    end else if (rd_req && !rd_valid && wait_reg >= lat) begin
      wait_reg <= 4'h0;
      rd_valid <= 1'b1;
      rd_data  <= rd_addr[7:0] ^ 8'h5a;
    end else begin
      wait_reg <= rd_valid ? 4'h0 : wait_reg + {3'h0, rd_req};
      rd_valid <= 1'b0;
      rd_data  <= ~rd_data; // between answers the stale byte alternates with its inverse
    end
  end
  assign wr_ready = !stall;
endmodule

// ==== tb/bmv_core_sva.sv ====
// assertions on the block-move unit ports
`timescale 1ns/1ps
module bmv_core_sva (
  // clock, reset, move
  input wire logic        MCLK, ARST_N, START, WORD_MODE, EXR_VALID, BUSY, DONE, RD_REQ, RD_VALID,
  input wire logic [15:0] COUNT_IN,
  input wire logic [31:0] RD_ADDR, OPND_A, OPND_B,
  // save/restore and flags
  input wire logic [2:0]  LDM_REGS,
  input wire logic [3:0]  LDM_STATES,
  input wire logic [1:0]  FLAG_OP, FLAG_SIZE, FLAG_STATES,
  input wire logic        FLAG_REQ, OPND_SUB, ZERO_IN, HALF_CARRY, ZERO_FLAG, DIV_FLAG
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  // expected flag inputs, from the operands, and the zero-count case of a move
  wire hc_w = OPND_SUB ? (OPND_A[11:0] < OPND_B[11:0]) : ({1'b0, OPND_A[11:0]} + {1'b0, OPND_B[11:0]} > 13'h0fff);
  wire hc_l = OPND_SUB ? (OPND_A[27:0] < OPND_B[27:0]) : ({1'b0, OPND_A[27:0]} + {1'b0, OPND_B[27:0]} > 29'h0fffffff);
  wire neg_b = (FLAG_SIZE == 2'h0) ? OPND_B[7] : (FLAG_SIZE == 2'h1) ? OPND_B[15] : OPND_B[31];
  wire zero_cnt = WORD_MODE ? (COUNT_IN == 16'h0000) : (COUNT_IN[7:0] == 8'h00);
  chk_done_one_cycle: assert property (DONE |=> !DONE) else $error("done longer than one cycle");
  chk_ldm_two_regs: assert property (LDM_REGS == 3'h2 |=> LDM_STATES == 4'h7) else $error("two-reg count");
  chk_ldm_four_regs: assert property (LDM_REGS == 3'h4 |=> LDM_STATES == 4'hb) else $error("four-reg count");
  chk_flag_exr_state: assert property (FLAG_REQ |=> FLAG_STATES == ($past(EXR_VALID) ? 2'h2 : 2'h1))
    else $error("flag state count");
  chk_zero_move_idle: assert property (START && !BUSY && !DONE && zero_cnt |=> !RD_REQ [*3] ##1 DONE)
    else $error("zero move not idle");
  chk_read_held: assert property (RD_REQ && !RD_VALID && !$past(RD_VALID) |=> RD_REQ && $stable(RD_ADDR))
    else $error("read dropped early");
  chk_half_carry_word: assert property (FLAG_REQ && FLAG_OP == 2'h0 && FLAG_SIZE == 2'h1
    |=> HALF_CARRY == $past(hc_w)) else $error("word half-carry");
  chk_half_carry_long: assert property (FLAG_REQ && FLAG_OP == 2'h0 && FLAG_SIZE == 2'h2
    |=> HALF_CARRY == $past(hc_l)) else $error("longword half-carry");
  chk_zero_keep: assert property (FLAG_REQ && FLAG_OP == 2'h1 && FLAG_SIZE == 2'h2
    |=> ZERO_FLAG == ($past(OPND_A) == 32'h0 && $past(ZERO_IN))) else $error("extended zero");
  chk_div_sign: assert property (FLAG_REQ && FLAG_OP == 2'h2 |=> DIV_FLAG == $past(neg_b))
    else $error("divisor sign");
  // main scenarios
  cover property (START && !BUSY && zero_cnt);
  cover property (RD_REQ && RD_VALID);
  cover property (FLAG_REQ && FLAG_OP == 2'h2);
endmodule
bind bmv_core bmv_core_sva bmv_core_sva_i (.*);

// ==== tb/bmv_core_tb.sv ====
// testbench: block moves, save/restore counts and flag cases
`timescale 1ns/1ps
module bmv_core_tb;
  logic MCLK, ARST_N, START, WORD_MODE, EXR_VALID, OFF_CHIP_WAIT, BUSY, DONE, RD_REQ, RD_VALID, WR_REQ, WR_READY;
  logic FLAG_REQ, OPND_SUB, ZERO_IN, HALF_CARRY, ZERO_FLAG, DIV_FLAG, stall;
  logic [31:0] SRC_PTR_IN, DST_PTR_IN, SRC_PTR_OUT, DST_PTR_OUT, RD_ADDR, WR_ADDR, OPND_A, OPND_B;
  logic [15:0] COUNT_IN, STATE_COUNT, COUNT_OUT;
  logic [7:0]  RD_DATA, WR_DATA;
  logic [3:0]  LDM_STATES, lat;
  logic [2:0]  LDM_REGS;
  logic [1:0]  FLAG_OP, FLAG_SIZE, FLAG_STATES;
  int          fail_count, n_compared;
  // ordinary moves: mode, count, ext reg, then expected bytes and states
  typedef struct {logic w; logic [15:0] c; logic x; logic [15:0] n; logic [15:0] st;} bmv_row_t;
  bmv_row_t rows [6] = '{'{1'b0, 16'h0000, 1'b0, 16'h0000, 16'h0004}, '{1'b0, 16'h0001, 1'b0, 16'h0001, 16'h0006},
    '{1'b0, 16'h0105, 1'b1, 16'h0005, 16'h000e}, '{1'b1, 16'h0000, 1'b1, 16'h0000, 16'h0004},
    '{1'b1, 16'h0009, 1'b0, 16'h0009, 16'h0016}, '{1'b1, 16'h0102, 1'b0, 16'h0102, 16'h0208}};
  bmv_core bmv_core_i (.*);
  bmv_mem_model bmv_mem_model_i (.clk(MCLK), .arst_n(ARST_N), .rd_req(RD_REQ), .rd_addr(RD_ADDR),
    .rd_valid(RD_VALID), .rd_data(RD_DATA), .wr_ready(WR_READY), .stall(stall), .lat(lat));
  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // start one move and wait, bounded, for its done pulse
  task automatic move(input logic w, input logic [15:0] c, input logic x);
    int cyc;
    @(posedge MCLK);
    START <= 1'b1; WORD_MODE <= w; COUNT_IN <= c; EXR_VALID <= x;
    @(posedge MCLK);
    START <= 1'b0;
    @(posedge MCLK) #1;
    chk(BUSY, 1'b1);
    for (cyc = 0; cyc < 3000 && DONE !== 1'b1; cyc++) @(posedge MCLK) #1;
    chk(DONE, 1'b1);
    chk(BUSY, 1'b0);
  endtask
  task automatic flag(input logic [1:0] op, sz, input logic [31:0] a, b, input logic sub, z, x, e);
    @(posedge MCLK);
    FLAG_REQ <= 1'b1; FLAG_OP <= op; FLAG_SIZE <= sz; OPND_A <= a; OPND_B <= b; OPND_SUB <= sub; ZERO_IN <= z;
    EXR_VALID <= x;
    @(posedge MCLK);
    FLAG_REQ <= 1'b0;
    #1;
    chk((op == 2'h0) ? HALF_CARRY : (op == 2'h1) ? ZERO_FLAG : DIV_FLAG, e);
    chk(FLAG_STATES, x ? 2'h2 : 2'h1);
  endtask
  // each write offered while WR_READY is high carries the byte of the matching source address
  always @(negedge MCLK) if (WR_REQ === 1'b1 && WR_READY) chk(WR_DATA, 8'(WR_ADDR - DST_PTR_IN + SRC_PTR_IN) ^ 8'h5a);
  // watchdog, far beyond the expected run of under two thousand cycles
  initial begin
    repeat (20000) @(posedge MCLK);
    fail_count++;
    results;
  end
  initial begin
    ARST_N = 1'b0; START = 1'b0; WORD_MODE = 1'b0; EXR_VALID = 1'b0; OFF_CHIP_WAIT = 1'b0; COUNT_IN = 16'h0000;
    SRC_PTR_IN = 32'h0000_1000; DST_PTR_IN = 32'h0000_2000; LDM_REGS = 3'h0; FLAG_REQ = 1'b0; FLAG_OP = 2'h0;
    FLAG_SIZE = 2'h0; OPND_A = 32'h0; OPND_B = 32'h0; OPND_SUB = 1'b0; ZERO_IN = 1'b0; stall = 1'b0; lat = 4'h1;
    repeat (20) @(posedge MCLK);
    ARST_N <= 1'b1;
    #1;
    chk({BUSY, DONE, RD_REQ, WR_REQ, STATE_COUNT}, 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      move(rows[i].w, rows[i].c, rows[i].x);
      chk(STATE_COUNT, rows[i].st);
      chk(COUNT_OUT, 16'h0000);
      chk(SRC_PTR_OUT, SRC_PTR_IN + rows[i].n);
      chk(DST_PTR_OUT, DST_PTR_IN + rows[i].n);
      $display("test move row %0d done", i);
    end
    // slow reads, writes stalled until the fifo fills, second start while busy
    lat <= 4'h5;
    fork
      move(1'b1, 16'h0014, 1'b0);
      begin
        stall <= 1'b1;
        repeat (6) @(posedge MCLK);
        START <= 1'b1; COUNT_IN <= 16'h0003;
        @(posedge MCLK);
        START <= 1'b0;
        repeat (60) @(posedge MCLK);
        stall <= 1'b0;
      end
    join
    chk(STATE_COUNT, 16'h002c);
    chk(SRC_PTR_OUT, SRC_PTR_IN + 32'h14);
    $display("test stalled move done");
    OFF_CHIP_WAIT <= 1'b1;
    move(1'b0, 16'h0004, 1'b0);
    OFF_CHIP_WAIT <= 1'b0;
    chk(STATE_COUNT > 16'h000c, 1'b1);
    $display("test off-chip move done");
    for (int r = 0; r < 8; r++) begin
      @(posedge MCLK);
      LDM_REGS <= 3'(r);
      @(posedge MCLK) #1;
      chk(LDM_STATES, (r == 2) ? 4'h7 : (r == 3) ? 4'h9 : (r == 4) ? 4'hb : 4'h0);
    end
    $display("test save/restore done");
    flag(2'h0, 2'h1, 32'h0800, 32'h0800, 1'b0, 1'b0, 1'b0, 1'b1);
    flag(2'h0, 2'h1, 32'h0801, 32'h07fe, 1'b0, 1'b0, 1'b1, 1'b0);
    flag(2'h0, 2'h1, 32'h0000, 32'h0001, 1'b1, 1'b0, 1'b0, 1'b1);
    flag(2'h0, 2'h2, 32'h0800_0000, 32'h0800_0000, 1'b0, 1'b0, 1'b0, 1'b1);
    flag(2'h0, 2'h2, 32'h0000_0800, 32'h0000_0800, 1'b0, 1'b0, 1'b0, 1'b0);
    flag(2'h1, 2'h2, 32'h0, 32'h0, 1'b0, 1'b1, 1'b0, 1'b1);
    flag(2'h1, 2'h2, 32'h5, 32'h0, 1'b0, 1'b1, 1'b1, 1'b0);
    flag(2'h1, 2'h2, 32'h0, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    flag(2'h2, 2'h0, 32'h0, 32'h0080, 1'b0, 1'b0, 1'b0, 1'b1);
    flag(2'h2, 2'h1, 32'h0, 32'h0080, 1'b0, 1'b0, 1'b0, 1'b0);
    flag(2'h2, 2'h2, 32'h0, 32'h8000_0000, 1'b0, 1'b0, 1'b0, 1'b1);
    $display("test flags done");
    results;
  end
endmodule
